// ==== dv/scr_host_model.sv ====
`timescale 1ns/1ps
module scr_host_model
  import scr_pkg::*;
(
  input wire logic CLK,
  output scr_pkg::scr_wr_s REG_WR,
  output logic REG_RD_EN,
  output logic [4:0] REG_RD_ADDR,
  input wire logic [7:0] REG_RD_DATA,
  input wire logic REG_RD_VALID
);
  initial
  begin
    REG_WR = '0;
    REG_RD_EN = 1'b0;
    REG_RD_ADDR = 5'h00;
  end

  // Released address and data lines show the inverse so stale values never look valid.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == ADDR_STEP_CFG) ? (d | 8'h08) : d;
    // The absolute position clear after a resolution change is sent elsewhere.
    @(negedge CLK);
    REG_WR <= '{en: 1'b1, addr: a, data: v};
    @(negedge CLK);
    REG_WR <= '{en: 1'b0, addr: ~a, data: ~v};
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic vld);
    @(negedge CLK);
    REG_RD_EN <= 1'b1;
    REG_RD_ADDR <= a;
    @(negedge CLK);
    REG_RD_EN <= 1'b0;
    REG_RD_ADDR <= ~a;
    d = REG_RD_DATA;
    vld = REG_RD_VALID;
  endtask : rd
endmodule : scr_host_model

// ==== dv/test_stepper_cfg_sync_alarm_regs.sv ====
`timescale 1ns/1ps
module test_stepper_cfg_sync_alarm_regs;
  import scr_pkg::*;
  logic CLK, RST_N, REG_RD_EN, REG_RD_VALID, MOTOR_RUNNING, CMD_BUSY, STATUS_CLR;
  logic ELEC_POS_RST, CMD_NOT_PERFORMED, BUSY_SYNC, ALARM_N;
  scr_wr_s REG_WR;
  logic [4:0] REG_RD_ADDR, ADC_RESULT;
  logic [7:0] REG_RD_DATA, m, c;
  logic [8:0] ELEC_POSITION;
  scr_alarm_s ALARM_COND;
  logic [6:0] MIN_OFF_TIME;
  logic [3:0] OVERCURRENT_THRESHOLD;
  scr_res_e STEP_RES;
  logic [2:0] prev;
  int mismatches = 0, checked = 0, seed = 42376;

  scr_regs dut (.CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD_EN(REG_RD_EN),
    .REG_RD_ADDR(REG_RD_ADDR), .REG_RD_DATA(REG_RD_DATA), .REG_RD_VALID(REG_RD_VALID),
    .MOTOR_RUNNING(MOTOR_RUNNING), .CMD_BUSY(CMD_BUSY), .ELEC_POSITION(ELEC_POSITION),
    .ADC_RESULT(ADC_RESULT), .ALARM_COND(ALARM_COND), .STATUS_CLR(STATUS_CLR),
    .MIN_OFF_TIME(MIN_OFF_TIME), .OVERCURRENT_THRESHOLD(OVERCURRENT_THRESHOLD),
    .STEP_RES(STEP_RES), .ELEC_POS_RST(ELEC_POS_RST), .CMD_NOT_PERFORMED(CMD_NOT_PERFORMED),
    .BUSY_SYNC(BUSY_SYNC), .ALARM_N(ALARM_N));
  scr_host_model host (.CLK(CLK), .REG_WR(REG_WR), .REG_RD_EN(REG_RD_EN),
    .REG_RD_ADDR(REG_RD_ADDR), .REG_RD_DATA(REG_RD_DATA), .REG_RD_VALID(REG_RD_VALID));

  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] res_of(input logic [2:0] s);
    return s[2] ? 3'h4 : s;
  endfunction : res_of

  function automatic logic sync_exp(input logic [2:0] s, input logic [2:0] r,
                                    input logic [8:0] p);
    if (s > 3'h4 || s > res_of(r))
      return 1'b0;
    return p[3'h7 - s];
  endfunction : sync_exp

  function automatic logic alarm_exp(input logic [7:0] mk, input logic [7:0] cd,
                                     input logic f);
    return !(|(mk & {cd[7] | f, cd[6], 2'b00, cd[3:0]}));
  endfunction : alarm_exp

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk("read_valid", {7'h00, v}, 8'h01);
    chk(nm, d, e);
  endtask : rdchk

  task automatic clr_flag();
    STATUS_CLR = 1'b1;
    @(negedge CLK);
    STATUS_CLR = 1'b0;
    chk("not_performed", {7'h00, CMD_NOT_PERFORMED}, 8'h00);
  endtask : clr_flag

  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    complete_run();
  end

  initial
  begin
    RST_N = 1'b0;
    MOTOR_RUNNING = 1'b0;
    CMD_BUSY = 1'b0;
    ELEC_POSITION = 9'h000;
    ADC_RESULT = 5'h00;
    ALARM_COND = '0;
    STATUS_CLR = 1'b0;
    repeat (6) @(negedge CLK);
    RST_N = 1'b1;
    chk("alarm_pin", {7'h00, ALARM_N}, 8'h01);
    rdchk("min_off", ADDR_MIN_OFF, {1'b0, RST_MIN_OFF});
    rdchk("oc_th", ADDR_OC_THRESHOLD, {4'h0, RST_OC_THRESHOLD});
    rdchk("step_cfg", ADDR_STEP_CFG, RST_STEP_CFG);
    rdchk("mask", ADDR_ALARM_MASK, RST_ALARM_MASK);
    rdchk("unmapped", 5'h1F, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      m = (i == 0) ? 8'h7F : (i == 1) ? 8'h00 : $random(seed);
      host.wr(ADDR_MIN_OFF, m);
      chk("min_off", {1'b0, MIN_OFF_TIME}, {1'b0, m[6:0]});
      host.wr(ADDR_OC_THRESHOLD, ~m);
      chk("oc_out", {4'h0, OVERCURRENT_THRESHOLD}, {4'h0, ~m[3:0]});
      rdchk("oc_th", ADDR_OC_THRESHOLD, {4'h0, ~m[3:0]});
    end
    MOTOR_RUNNING = 1'b1;
    host.wr(ADDR_MIN_OFF, 8'h15);
    chk("min_off", {1'b0, MIN_OFF_TIME}, {1'b0, m[6:0]});
    chk("not_performed", {7'h00, CMD_NOT_PERFORMED}, 8'h01);
    host.wr(ADDR_STEP_CFG, 8'h0C);
    chk("step_res", {5'h00, STEP_RES}, 8'h00);
    chk("pos_rst", {7'h00, ELEC_POS_RST}, 8'h00);
    host.wr(ADDR_OC_THRESHOLD, 8'h05);
    chk("oc_out", {4'h0, OVERCURRENT_THRESHOLD}, 8'h05);
    MOTOR_RUNNING = 1'b0;
    clr_flag();
    ADC_RESULT = $random(seed);
    host.wr(ADDR_ADC_RESULT, 8'hFF);
    chk("not_performed", {7'h00, CMD_NOT_PERFORMED}, 8'h01);
    rdchk("adc", ADDR_ADC_RESULT, {3'h0, ADC_RESULT});
    // The clear stands through the rejected write, so both meet on one edge.
    STATUS_CLR = 1'b1;
    host.wr(ADDR_ADC_RESULT, 8'h00);
    STATUS_CLR = 1'b0;
    chk("not_performed", {7'h00, CMD_NOT_PERFORMED}, 8'h01);
    clr_flag();
    prev = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      host.wr(ADDR_STEP_CFG, {5'h01, i[2:0]});
      chk("step_res", {5'h00, STEP_RES}, {5'h00, res_of(i[2:0])});
      chk("pos_rst", {7'h00, ELEC_POS_RST}, {7'h00, res_of(i[2:0]) != prev});
      prev = res_of(i[2:0]);
    end
    CMD_BUSY = 1'b1;
    @(negedge CLK);
    chk("busy_sync", {7'h00, BUSY_SYNC}, 8'h00);
    CMD_BUSY = 1'b0;
    @(negedge CLK);
    chk("busy_sync", {7'h00, BUSY_SYNC}, 8'h01);
    for (int r = 0; r < 5; r++)
      for (int s = 0; s < 8; s++)
      begin
        host.wr(ADDR_STEP_CFG, {1'b1, s[2:0], 1'b1, r[2:0]});
        repeat (4)
        begin
          ELEC_POSITION = $random(seed);
          CMD_BUSY = $random(seed);
          @(negedge CLK);
          chk("sync", {7'h00, BUSY_SYNC}, {7'h00, sync_exp(s[2:0], r[2:0], ELEC_POSITION)});
        end
      end
    for (int i = 0; i < 30; i++)
    begin
      m = (i == 0) ? 8'h30 : (i == 1) ? 8'h00 : $random(seed);
      c = (i == 0) ? 8'h30 : (i == 1) ? 8'hFF : $random(seed);
      host.wr(ADDR_ALARM_MASK, m);
      ALARM_COND = c;
      @(negedge CLK);
      chk("alarm_pin", {7'h00, ALARM_N}, {7'h00, alarm_exp(m, c, 1'b0)});
    end
    ALARM_COND = '0;
    host.wr(ADDR_ALARM_MASK, 8'h80);
    host.wr(ADDR_ADC_RESULT, 8'h01);
    @(negedge CLK);
    chk("alarm_pin", {7'h00, ALARM_N}, {7'h00, alarm_exp(8'h80, 8'h00, 1'b1)});
    clr_flag();
    @(negedge CLK);
    chk("alarm_pin", {7'h00, ALARM_N}, 8'h01);
    complete_run();
  end
endmodule : test_stepper_cfg_sync_alarm_regs

// ==== inc/scr_pkg.sv ====
package scr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register addresses on the command register port.
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] ADDR_MIN_OFF = 5'h01;
  localparam logic [4:0] ADDR_ADC_RESULT = 5'h02;
  localparam logic [4:0] ADDR_OC_THRESHOLD = 5'h03;
  localparam logic [4:0] ADDR_STEP_CFG = 5'h04;
  localparam logic [4:0] ADDR_ALARM_MASK = 5'h05;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [6:0] RST_MIN_OFF = 7'h00;
  localparam logic [4:0] RST_ADC_RESULT = 5'h00;
  localparam logic [3:0] RST_OC_THRESHOLD = 4'h8;
  localparam logic [7:0] RST_STEP_CFG = 8'h08;
  localparam logic [7:0] RST_ALARM_MASK = 8'hFF;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions and widths.
  localparam int unsigned MIN_OFF_W = 7;
  localparam int unsigned ADC_W = 5;
  localparam int unsigned OC_W = 4;
  localparam int unsigned ELEC_POS_W = 9;
  localparam int unsigned SYNC_TOP_BIT = 7;
  localparam logic [2:0] SYNC_SEL_LAST = 3'h4;

  // Time per code step of the minimum off time, and its cycle count at 125 MHz.
  localparam int unsigned MIN_OFF_STEP_PS = 500000;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned MIN_OFF_STEP_CYC = (MIN_OFF_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  //////////////////////////////////////////////////////////////////////////////
  // Step resolutions, ordered from coarsest to finest.
  typedef enum logic [2:0] {
    SCR_RES_FULL = 3'h0,
    SCR_RES_HALF = 3'h1,
    SCR_RES_QUARTER = 3'h2,
    SCR_RES_EIGHTH = 3'h3,
    SCR_RES_SIXTEENTH = 3'h4
  } scr_res_e;

  typedef struct packed {
    logic sync_en;
    logic [2:0] sync_sel;
    logic fixed_one;
    logic [2:0] step_sel;
  } scr_step_cfg_s;

  typedef struct packed {
    logic cmd_fault;
    logic sw_event;
    logic [1:0] unused;
    logic undervolt;
    logic th_warn;
    logic th_shutdown;
    logic overcurrent;
  } scr_alarm_s;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } scr_wr_s;

endpackage : scr_pkg

// ==== src/scr_alarm_out.sv ====
`timescale 1ns/1ps
module scr_alarm_out
  import scr_pkg::*;
(
  input wire logic [7:0] alarm_mask,
  input wire scr_pkg::scr_alarm_s alarm_cond,
  output logic alarm_active
);
  wire logic [7:0] gated = alarm_mask & alarm_cond;

  // Unused positions never raise the pin, whatever the mask holds.
  assign alarm_active = |{gated[7:6], gated[3:0]};

endmodule : scr_alarm_out

// ==== src/scr_regs.sv ====
`timescale 1ns/1ps
// What this block does
// - Holds a 7-bit minimum off time, 0.5 us per code from 0.5 us.
// - Minimum off time write while running is dropped and flags not-performed.
// - Read-only 5-bit analog conversion result, steps of 1/32 reference.
// - Any write to the conversion result is dropped and flags not-performed.
// - Holds a 4-bit overcurrent threshold, 375 mA per code.
// - Step field decodes full, half, quarter, eighth; top bit set means sixteenth.
// - A change of step resolution resets the electrical position.
// - Stepping config write while running is dropped and flags not-performed.
// - With sync disabled, busy/sync pin is low while a command executes.
// - With sync enabled, pin shows electrical position bit 7 down to 3.
// - Sync source codes 101 to 111 force the pin low.
// - Sync rate is half, 1x, 2x, 4x, 8x full-step; finer than resolution is unusable.
// - Each masked-in active alarm condition pulls the alarm pin low.
// - Mask bits: overcurrent, thermal stop, thermal warning, undervoltage, -, -, switch, command.
// - Raises a sticky active-high flag when a command cannot be carried out.
module scr_regs
  import scr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire scr_pkg::scr_wr_s REG_WR,
  input wire logic REG_RD_EN,
  input wire logic [scr_pkg::ADDR_W-1:0] REG_RD_ADDR,
  output logic [7:0] REG_RD_DATA,
  output logic REG_RD_VALID,
  input wire logic MOTOR_RUNNING,
  input wire logic CMD_BUSY,
  input wire logic [scr_pkg::ELEC_POS_W-1:0] ELEC_POSITION,
  input wire logic [scr_pkg::ADC_W-1:0] ADC_RESULT,
  input wire scr_pkg::scr_alarm_s ALARM_COND,
  input wire logic STATUS_CLR,
  output logic [scr_pkg::MIN_OFF_W-1:0] MIN_OFF_TIME,
  output logic [scr_pkg::OC_W-1:0] OVERCURRENT_THRESHOLD,
  output scr_pkg::scr_res_e STEP_RES,
  output logic ELEC_POS_RST,
  output logic CMD_NOT_PERFORMED,
  output logic BUSY_SYNC,
  output logic ALARM_N
);
  import scr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [MIN_OFF_W-1:0] min_off_q;
  logic [ADC_W-1:0] adc_q;
  logic [OC_W-1:0] oc_th_q;
  scr_step_cfg_s step_cfg_q;
  logic [7:0] alarm_mask_q;
  scr_res_e step_res_q;
  logic notperf_q;
  logic notperf_d;
  logic elec_rst_q;
  logic busy_sync_q;
  logic alarm_n_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  //////////////////////////////////////////////////////////////////////////////
  // Write decode.
  wire logic wr_min_off = REG_WR.en && (REG_WR.addr == ADDR_MIN_OFF);
  wire logic wr_adc = REG_WR.en && (REG_WR.addr == ADDR_ADC_RESULT);
  wire logic wr_oc = REG_WR.en && (REG_WR.addr == ADDR_OC_THRESHOLD);
  wire logic wr_step = REG_WR.en && (REG_WR.addr == ADDR_STEP_CFG);
  wire logic wr_mask = REG_WR.en && (REG_WR.addr == ADDR_ALARM_MASK);

  wire logic take_min_off = wr_min_off && !MOTOR_RUNNING;
  wire logic take_step = wr_step && !MOTOR_RUNNING;
  // The conversion result is never writable, whatever the motor does.
  wire logic reject = wr_adc || ((wr_min_off || wr_step) && MOTOR_RUNNING);

  wire scr_step_cfg_s step_wr = REG_WR.data;
  // Any code with the top bit set is the finest resolution.
  wire scr_res_e res_wr = step_wr.step_sel[2] ? SCR_RES_SIXTEENTH
                        : scr_res_e'({1'b0, step_wr.step_sel[1:0]});
  wire logic res_change = take_step && (res_wr != step_res_q);

  //////////////////////////////////////////////////////////////////////////////
  // Not-performed flag: a new rejection wins over a clear in the same cycle.
  always_comb
  begin
    notperf_d = notperf_q;
    if (STATUS_CLR)
    begin
      notperf_d = 1'b0;
    end
    if (reject)
    begin
      notperf_d = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read decode.
  wire logic [7:0] rd_mux =
    (REG_RD_ADDR == ADDR_MIN_OFF) ? {1'b0, min_off_q} :
    (REG_RD_ADDR == ADDR_ADC_RESULT) ? {3'h0, adc_q} :
    (REG_RD_ADDR == ADDR_OC_THRESHOLD) ? {4'h0, oc_th_q} :
    (REG_RD_ADDR == ADDR_STEP_CFG) ? step_cfg_q :
    (REG_RD_ADDR == ADDR_ALARM_MASK) ? alarm_mask_q : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Pin logic helpers.
  logic sync_level;
  logic alarm_active;
  wire scr_alarm_s alarm_eff = {ALARM_COND.cmd_fault | notperf_q, ALARM_COND[6:0]};

  scr_sync_sel u_sync_sel (
    .sync_en(step_cfg_q.sync_en),
    .sync_sel(step_cfg_q.sync_sel),
    .step_res(step_res_q),
    .cmd_busy(CMD_BUSY),
    .elec_position(ELEC_POSITION),
    .sync_level(sync_level)
  );

  scr_alarm_out u_alarm_out (
    .alarm_mask(alarm_mask_q),
    .alarm_cond(alarm_eff),
    .alarm_active(alarm_active)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      min_off_q <= RST_MIN_OFF;
      oc_th_q <= RST_OC_THRESHOLD;
      step_cfg_q <= RST_STEP_CFG;
      alarm_mask_q <= RST_ALARM_MASK;
      step_res_q <= SCR_RES_FULL;
    end
    else
    begin
      if (take_min_off)
      begin
        min_off_q <= REG_WR.data[MIN_OFF_W-1:0];
      end
      if (wr_oc)
      begin
        oc_th_q <= REG_WR.data[OC_W-1:0];
      end
      if (take_step)
      begin
        step_cfg_q <= step_wr;
        step_res_q <= res_wr;
      end
      if (wr_mask)
      begin
        alarm_mask_q <= REG_WR.data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status, pins and read port.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      adc_q <= RST_ADC_RESULT;
      notperf_q <= 1'b0;
      elec_rst_q <= 1'b0;
      busy_sync_q <= 1'b1;
      alarm_n_q <= 1'b1;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      adc_q <= ADC_RESULT;
      notperf_q <= notperf_d;
      elec_rst_q <= res_change;
      busy_sync_q <= sync_level;
      alarm_n_q <= ~alarm_active;
      rd_valid_q <= REG_RD_EN;
      if (REG_RD_EN)
      begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign MIN_OFF_TIME = min_off_q;
  assign OVERCURRENT_THRESHOLD = oc_th_q;
  assign STEP_RES = step_res_q;
  assign ELEC_POS_RST = elec_rst_q;
  assign CMD_NOT_PERFORMED = notperf_q;
  assign BUSY_SYNC = busy_sync_q;
  assign ALARM_N = alarm_n_q;
  assign REG_RD_DATA = rd_data_q;
  assign REG_RD_VALID = rd_valid_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_min_off_blocked;
    @(posedge CLK) disable iff (!RST_N)
    (wr_min_off && MOTOR_RUNNING) |=> ($stable(MIN_OFF_TIME) && CMD_NOT_PERFORMED);
  endproperty
  a_min_off_blocked: assert property (p_min_off_blocked)
    else $error("Minimum off time written while running.");

  property p_min_off_taken;
    @(posedge CLK) disable iff (!RST_N)
    take_min_off |=> (MIN_OFF_TIME == $past(REG_WR.data[MIN_OFF_W-1:0]));
  endproperty
  a_min_off_taken: assert property (p_min_off_taken)
    else $error("Minimum off time write lost.");

  property p_adc_write_flag;
    @(posedge CLK) disable iff (!RST_N)
    wr_adc |=> CMD_NOT_PERFORMED;
  endproperty
  a_adc_write_flag: assert property (p_adc_write_flag)
    else $error("Conversion result write did not raise the flag.");

  property p_adc_read;
    @(posedge CLK) disable iff (!RST_N)
    (REG_RD_EN && (REG_RD_ADDR == ADDR_ADC_RESULT)) ##1 1'b1
      |-> (REG_RD_VALID && (REG_RD_DATA == {3'h0, $past(ADC_RESULT, 2)}));
  endproperty
  a_adc_read: assert property (p_adc_read)
    else $error("Conversion result read mismatch.");

  property p_step_blocked;
    @(posedge CLK) disable iff (!RST_N)
    (wr_step && MOTOR_RUNNING) |=> ($stable(STEP_RES) && !ELEC_POS_RST && CMD_NOT_PERFORMED);
  endproperty
  a_step_blocked: assert property (p_step_blocked)
    else $error("Stepping config written while running.");

  property p_sixteenth;
    @(posedge CLK) disable iff (!RST_N)
    (take_step && REG_WR.data[2]) |=> (STEP_RES == SCR_RES_SIXTEENTH);
  endproperty
  a_sixteenth: assert property (p_sixteenth)
    else $error("Top step bit did not select sixteenth.");

  property p_elec_reset;
    @(posedge CLK) disable iff (!RST_N)
    (take_step && (res_wr != STEP_RES)) |=> ELEC_POS_RST;
  endproperty
  a_elec_reset: assert property (p_elec_reset)
    else $error("Resolution change did not pulse the position reset.");

  property p_elec_quiet;
    @(posedge CLK) disable iff (!RST_N)
    !(take_step && (res_wr != STEP_RES)) |=> !ELEC_POS_RST;
  endproperty
  a_elec_quiet: assert property (p_elec_quiet)
    else $error("Position reset pulsed without a resolution change.");

  property p_res_coarse;
    @(posedge CLK) disable iff (!RST_N)
    (take_step && !REG_WR.data[2])
      |=> (3'(STEP_RES) == {1'b0, $past(REG_WR.data[1:0])});
  endproperty
  a_res_coarse: assert property (p_res_coarse)
    else $error("Coarse step code decoded wrongly.");

  property p_oc_taken;
    @(posedge CLK) disable iff (!RST_N)
    wr_oc |=> (OVERCURRENT_THRESHOLD == $past(REG_WR.data[OC_W-1:0]));
  endproperty
  a_oc_taken: assert property (p_oc_taken)
    else $error("Overcurrent threshold write lost.");

  property p_mask_taken;
    @(posedge CLK) disable iff (!RST_N)
    wr_mask |=> (alarm_mask_q == $past(REG_WR.data));
  endproperty
  a_mask_taken: assert property (p_mask_taken)
    else $error("Alarm mask write lost.");

  property p_busy_low;
    @(posedge CLK) disable iff (!RST_N)
    (!step_cfg_q.sync_en && CMD_BUSY) |=> !BUSY_SYNC;
  endproperty
  a_busy_low: assert property (p_busy_low)
    else $error("Busy pin not low during command.");

  property p_sync_top;
    @(posedge CLK) disable iff (!RST_N)
    (step_cfg_q.sync_en && (step_cfg_q.sync_sel == 3'h0))
      |=> (BUSY_SYNC == $past(ELEC_POSITION[SYNC_TOP_BIT]));
  endproperty
  a_sync_top: assert property (p_sync_top)
    else $error("Sync pin does not follow the top position bit.");

  property p_sync_unused;
    @(posedge CLK) disable iff (!RST_N)
    (step_cfg_q.sync_en && (step_cfg_q.sync_sel > SYNC_SEL_LAST)) |=> !BUSY_SYNC;
  endproperty
  a_sync_unused: assert property (p_sync_unused)
    else $error("Unused sync source did not force the pin low.");

  property p_alarm_low;
    @(posedge CLK) disable iff (!RST_N)
    (|(alarm_mask_q & alarm_eff & 8'hCF)) |=> !ALARM_N;
  endproperty
  a_alarm_low: assert property (p_alarm_low)
    else $error("Enabled alarm did not pull the pin low.");

  property p_alarm_high;
    @(posedge CLK) disable iff (!RST_N)
    !(|(alarm_mask_q & alarm_eff & 8'hCF)) |=> ALARM_N;
  endproperty
  a_alarm_high: assert property (p_alarm_high)
    else $error("Alarm pin low with no enabled alarm.");

  property p_flag_sticky;
    @(posedge CLK) disable iff (!RST_N)
    (CMD_NOT_PERFORMED && !STATUS_CLR) |=> CMD_NOT_PERFORMED;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Not-performed flag dropped without a clear.");

  property p_flag_set_wins;
    @(posedge CLK) disable iff (!RST_N)
    (reject && STATUS_CLR) |=> CMD_NOT_PERFORMED;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("Clear beat a rejection in the same cycle.");

  property p_flag_clear;
    @(posedge CLK) disable iff (!RST_N)
    (STATUS_CLR && !reject) |=> !CMD_NOT_PERFORMED;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Not-performed flag survived a clear.");

  property p_rd_valid_once;
    @(posedge CLK) disable iff (!RST_N)
    !REG_RD_EN |=> !REG_RD_VALID;
  endproperty
  a_rd_valid_once: assert property (p_rd_valid_once)
    else $error("Read valid raised without a read.");

  property p_sync_unusable;
    @(posedge CLK) disable iff (!RST_N)
    (step_cfg_q.sync_en && (step_cfg_q.sync_sel <= SYNC_SEL_LAST)
      && (step_cfg_q.sync_sel > 3'(STEP_RES))) |=> !BUSY_SYNC;
  endproperty
  a_sync_unusable: assert property (p_sync_unusable)
    else $error("Sync finer than the resolution did not hold the pin low.");

  property p_busy_idle;
    @(posedge CLK) disable iff (!RST_N)
    (!step_cfg_q.sync_en && !CMD_BUSY) |=> BUSY_SYNC;
  endproperty
  a_busy_idle: assert property (p_busy_idle)
    else $error("Busy pin low with no command executing.");

endmodule : scr_regs

// ==== src/scr_sync_sel.sv ====
`timescale 1ns/1ps
module scr_sync_sel
  import scr_pkg::*;
(
  input wire logic sync_en,
  input wire logic [2:0] sync_sel,
  input wire scr_pkg::scr_res_e step_res,
  input wire logic cmd_busy,
  input wire logic [ELEC_POS_W-1:0] elec_position,
  output logic sync_level
);
  wire logic [2:0] bit_idx = 3'(SYNC_TOP_BIT[2:0] - sync_sel);
  wire logic sel_in_range = (sync_sel <= SYNC_SEL_LAST);
  // A selection finer than the step resolution has no defined rate.
  wire logic sel_usable = sel_in_range && (sync_sel <= 3'(step_res));
  wire logic src_bit = elec_position[bit_idx];

  assign sync_level = sync_en ? (sel_usable & src_bit) : ~cmd_busy;

endmodule : scr_sync_sel
